// ### verilog/upidc_cfg.svh
// timing counts and field constants for the usb isolator direction control
`ifndef UPIDC_CFG_SVH
`define UPIDC_CFG_SVH

// system clock and line bit rates, in kHz / kbit per second
`define UPIDC_CLK_KHZ        25000
`define UPIDC_FS_RATE_KBPS   12000
`define UPIDC_LS_RATE_KBPS   1500

// idle timeout in bit times: one more than the longest stuffed run of seven
`define UPIDC_TIMEOUT_BITS   8
`define UPIDC_TIMEOUT_FS_CYC ((`UPIDC_TIMEOUT_BITS * `UPIDC_CLK_KHZ + `UPIDC_FS_RATE_KBPS - 1) / `UPIDC_FS_RATE_KBPS)
`define UPIDC_TIMEOUT_LS_CYC ((`UPIDC_TIMEOUT_BITS * `UPIDC_CLK_KHZ + `UPIDC_LS_RATE_KBPS - 1) / `UPIDC_LS_RATE_KBPS)

// least cycles a rebuilt line state is held, per speed (slew shaping)
`define UPIDC_HOLD_FS_CYC    1
`define UPIDC_HOLD_LS_CYC    8

// synchronised input vector bit positions
`define UPIDC_IN_SPU         10
`define UPIDC_IN_SPD         9
`define UPIDC_IN_PULLUP      8
`define UPIDC_IN_UP_PG       7
`define UPIDC_IN_PD_PG       6
`define UPIDC_IN_UP_DP       5
`define UPIDC_IN_UP_DM       4
`define UPIDC_IN_UP_DIFF     3
`define UPIDC_IN_PD_DP       2
`define UPIDC_IN_PD_DM       1
`define UPIDC_IN_PD_DIFF     0
`define UPIDC_IN_W           11

// side indices
`define UPIDC_SIDE_UP        0
`define UPIDC_SIDE_PD        1

`endif

// ### verilog/upidc_pkg.sv
// types shared by the usb isolator direction control
package upidc_pkg;

    // the three line states that cross the barrier
    typedef enum logic [1:0] {
        UPIDC_SYM_SE0 = 2'h0,
        UPIDC_SYM_J   = 2'h1,
        UPIDC_SYM_K   = 2'h2
    } upidc_sym_t;

    // transfer direction state
    typedef enum logic [1:0] {
        UPIDC_ST_IDLE  = 2'h0,
        UPIDC_ST_UP2PD = 2'h1,
        UPIDC_ST_PD2UP = 2'h2
    } upidc_state_t;

endpackage : upidc_pkg

// ### verilog/upidc_top.sv
// packet-by-packet direction control and line rebuild for a usb port isolator
`timescale 1ns/1ps
`include "upidc_cfg.svh"

// How it works
// - while idle watch both sides; first to leave idle fixes direction
// - keep forwarding that way until end of packet or long idle
// - at transfer end release both sides' buffers and watch again
// - receiving side keeps its own line drivers off
// - driving side drives and ignores its own inputs, no loop back
// - each line condition is coded as J, K or SE0 only
// - never rebuild spurious SE0 or any SE1 on the driving side
// - timing follows the differential receiver, not single-ended ones
// - filter threshold glitches after classifying, before accepting a line state
// - rebuilt state appears a constant delay after the input transition, except where the low-speed hold stretches a short state
// - J/K polarity and slew come from the configured speed
// - upstream pull-up connects only when the peripheral side asks
// - traffic passes transparently apart from delayed pull-up
// - no suspend state; bus idle simply leaves block monitoring
// - pull-up connect low leaves upstream disconnected and undriven
// - upstream power loss floats peripheral drivers; start floated
// - peripheral power loss drops pull-up and upstream drivers
module upidc_top (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_upstream_speed_select,
    input  wire logic i_downstream_speed_select,
    input  wire logic i_pullup_connect,
    input  wire logic i_up_power_good,
    input  wire logic i_periph_power_good,
    input  wire logic i_up_dplus,
    input  wire logic i_up_dminus,
    input  wire logic i_up_diff,
    input  wire logic i_peripheral_side_dplus,
    input  wire logic i_peripheral_side_dminus,
    input  wire logic i_peripheral_side_diff,
    output logic      o_up_dplus,
    output logic      o_up_dminus,
    output logic      o_up_oe,
    output logic      o_up_pullup_dplus,
    output logic      o_up_pullup_dminus,
    output logic      o_peripheral_side_dplus,
    output logic      o_peripheral_side_dminus,
    output logic      o_peripheral_side_oe,
    output logic      o_full_speed,
    output logic      o_speed_mismatch,
    output upidc_pkg::upidc_state_t o_direction
);
    import upidc_pkg::*;

    localparam logic [7:0] TIMEOUT_FS = 8'(`UPIDC_TIMEOUT_FS_CYC);
    localparam logic [7:0] TIMEOUT_LS = 8'(`UPIDC_TIMEOUT_LS_CYC);
    localparam logic [3:0] HOLD_FS    = 4'(`UPIDC_HOLD_FS_CYC);
    localparam logic [3:0] HOLD_LS    = 4'(`UPIDC_HOLD_LS_CYC);

    // single-ended pair plus differential receiver to line state
    function automatic upidc_sym_t classify(input logic dp, input logic dm,
                                            input logic diff, input logic fs);
        if (!dp && !dm) begin
            classify = UPIDC_SYM_SE0;
        end else begin
            // an SE1 falls through to the differential answer, never rebuilt
            classify = (diff == fs) ? UPIDC_SYM_J : UPIDC_SYM_K;
        end
    endfunction : classify

    // line state to the two driven levels {dp, dm}
    function automatic logic [1:0] drive_levels(input upidc_sym_t s, input logic fs);
        case (s)
            UPIDC_SYM_SE0: drive_levels = 2'h0;
            UPIDC_SYM_J:   drive_levels = fs ? 2'h2 : 2'h1;
            UPIDC_SYM_K:   drive_levels = fs ? 2'h1 : 2'h2;
            default:       drive_levels = fs ? 2'h2 : 2'h1;
        endcase
    endfunction : drive_levels

    // ---------------- input synchroniser ----------------
    logic [`UPIDC_IN_W-1:0] raw_in;
    logic [`UPIDC_IN_W-1:0] sync1_reg;
    logic [`UPIDC_IN_W-1:0] sync1_next;
    logic [`UPIDC_IN_W-1:0] sync2_reg;
    logic [`UPIDC_IN_W-1:0] sync2_next;

    assign raw_in = {i_upstream_speed_select, i_downstream_speed_select, i_pullup_connect,
                     i_up_power_good, i_periph_power_good,
                     i_up_dplus, i_up_dminus, i_up_diff,
                     i_peripheral_side_dplus, i_peripheral_side_dminus,
                     i_peripheral_side_diff};

    // every pin crosses two flops before use
    always_comb begin
        sync1_next = raw_in;
        sync2_next = sync1_reg;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    // ---------------- static configuration ----------------
    logic fs;
    logic pullup_req;
    logic up_pg;
    logic pd_pg;
    logic up_ready;
    logic pd_ready;
    logic mismatch;

    // upstream select rules the convention; a mixed setting blocks transfers
    assign fs         = sync2_reg[`UPIDC_IN_SPU];
    assign mismatch   = sync2_reg[`UPIDC_IN_SPU] ^ sync2_reg[`UPIDC_IN_SPD];
    assign pullup_req = sync2_reg[`UPIDC_IN_PULLUP];
    assign up_pg      = sync2_reg[`UPIDC_IN_UP_PG];
    assign pd_pg      = sync2_reg[`UPIDC_IN_PD_PG];
    // both sides powered, attached and configured alike
    assign up_ready   = up_pg && pd_pg && pullup_req && !mismatch;
    assign pd_ready   = up_ready;

    // ---------------- glitch filter and classifier ----------------
    upidc_sym_t cand     [2];
    upidc_sym_t cand_reg [2];
    upidc_sym_t cand_next[2];
    upidc_sym_t acc_reg  [2];
    upidc_sym_t acc_next [2];
    logic       accept   [2];
    logic       fifo_full;
    upidc_state_t st_reg;

    assign cand[`UPIDC_SIDE_UP] = classify(sync2_reg[`UPIDC_IN_UP_DP], sync2_reg[`UPIDC_IN_UP_DM],
                                           sync2_reg[`UPIDC_IN_UP_DIFF], fs);
    assign cand[`UPIDC_SIDE_PD] = classify(sync2_reg[`UPIDC_IN_PD_DP], sync2_reg[`UPIDC_IN_PD_DM],
                                           sync2_reg[`UPIDC_IN_PD_DIFF], fs);

    // a candidate must stand two samples; a full buffer holds acceptance back
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            cand_next[s] = cand[s];
            accept[s]    = (cand[s] == cand_reg[s]) && (cand[s] != acc_reg[s]) &&
                           !fifo_full;
            acc_next[s]  = accept[s] ? cand[s] : acc_reg[s];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            for (int s = 0; s < 2; s++) begin
                cand_reg[s] <= UPIDC_SYM_J;
                acc_reg[s]  <= UPIDC_SYM_J;
            end
        end else begin
            for (int s = 0; s < 2; s++) begin
                cand_reg[s] <= cand_next[s];
                acc_reg[s]  <= acc_next[s];
            end
        end
    end

    // ---------------- direction state machine ----------------
    upidc_state_t st_next;
    logic         eop_reg;
    logic         eop_next;
    logic [7:0]   idle_cnt_reg;
    logic [7:0]   idle_cnt_next;
    logic         push;
    upidc_sym_t   push_sym;
    logic         flush;
    logic         rx_accept;
    upidc_sym_t   rx_sym;
    logic         drained;
    logic         fifo_empty;
    logic [3:0]   hold_cnt_reg;
    upidc_sym_t   out_sym_reg;

    // only the receiving side's classifier is heard during a transfer
    assign rx_accept = (st_reg == UPIDC_ST_UP2PD) ? accept[`UPIDC_SIDE_UP]
                                                  : accept[`UPIDC_SIDE_PD];
    assign rx_sym    = (st_reg == UPIDC_ST_UP2PD) ? cand[`UPIDC_SIDE_UP] : cand[`UPIDC_SIDE_PD];
    assign drained   = fifo_empty && (hold_cnt_reg == 4'h0);

    always_comb begin
        st_next       = st_reg;
        eop_next      = eop_reg;
        idle_cnt_next = idle_cnt_reg;
        push          = 1'b0;
        push_sym      = UPIDC_SYM_J;
        flush         = 1'b0;
        case (st_reg)
            UPIDC_ST_IDLE: begin
                // no suspend state: idle monitoring is the low-activity state
                eop_next      = 1'b0;
                idle_cnt_next = 8'h0;
                if (up_ready && accept[`UPIDC_SIDE_UP] && cand[`UPIDC_SIDE_UP] != UPIDC_SYM_J) begin
                    st_next  = UPIDC_ST_UP2PD;
                    push     = 1'b1;
                    push_sym = cand[`UPIDC_SIDE_UP];
                    eop_next = (cand[`UPIDC_SIDE_UP] == UPIDC_SYM_SE0);
                end else if (pd_ready && accept[`UPIDC_SIDE_PD] &&
                             cand[`UPIDC_SIDE_PD] != UPIDC_SYM_J) begin
                    st_next  = UPIDC_ST_PD2UP;
                    push     = 1'b1;
                    push_sym = cand[`UPIDC_SIDE_PD];
                    eop_next = (cand[`UPIDC_SIDE_PD] == UPIDC_SYM_SE0);
                end
            end
            UPIDC_ST_UP2PD, UPIDC_ST_PD2UP: begin
                if (rx_accept) begin
                    // every accepted change is forwarded unaltered
                    push          = 1'b1;
                    push_sym      = rx_sym;
                    idle_cnt_next = 8'h0;
                    if (rx_sym == UPIDC_SYM_SE0) begin
                        eop_next = 1'b1;
                    end
                end else if (idle_cnt_reg != 8'hFF) begin
                    idle_cnt_next = idle_cnt_reg + 8'h1;
                end
                // eop done once SE0 then J has been rebuilt and held
                if (!up_ready ||
                    (eop_reg && drained && out_sym_reg == UPIDC_SYM_J && !rx_accept) ||
                    (idle_cnt_reg >= (fs ? TIMEOUT_FS : TIMEOUT_LS))) begin
                    st_next = UPIDC_ST_IDLE;
                    flush   = 1'b1;
                end
            end
            default: begin
                st_next = UPIDC_ST_IDLE;
                flush   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            st_reg       <= UPIDC_ST_IDLE;
            eop_reg      <= 1'b0;
            idle_cnt_reg <= 8'h0;
        end else begin
            st_reg       <= st_next;
            eop_reg      <= eop_next;
            idle_cnt_reg <= idle_cnt_next;
        end
    end

    // ---------------- two-entry line-state buffer ----------------
    upidc_sym_t mem_reg [2];
    upidc_sym_t mem_next[2];
    logic       wr_ptr_reg;
    logic       wr_ptr_next;
    logic       rd_ptr_reg;
    logic       rd_ptr_next;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic       pop;
    logic       drain_ready;

    assign fifo_full   = (count_reg == 2'h2);
    assign fifo_empty  = (count_reg == 2'h0);
    // the driver stalls while a rebuilt state has not yet held its least time
    assign drain_ready = (hold_cnt_reg == 4'h0);
    assign pop         = !fifo_empty && drain_ready && !flush;

    always_comb begin
        mem_next    = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (flush) begin
            wr_ptr_next = 1'b0;
            rd_ptr_next = 1'b0;
            count_next  = 2'h0;
        end else begin
            if (push && !fifo_full) begin
                mem_next[wr_ptr_reg] = push_sym;
                wr_ptr_next          = ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_next = ~rd_ptr_reg;
            end
            count_next = count_reg + 2'((push && !fifo_full) ? 1 : 0) - 2'(pop ? 1 : 0);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            mem_reg[0] <= UPIDC_SYM_J;
            mem_reg[1] <= UPIDC_SYM_J;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            mem_reg    <= mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // ---------------- line driver stage ----------------
    upidc_sym_t out_sym_next;
    logic [3:0] hold_cnt_next;
    logic [1:0] lvl_reg;
    logic [1:0] lvl_next;
    logic       up_oe_reg;
    logic       up_oe_next;
    logic       pd_oe_reg;
    logic       pd_oe_next;
    logic       pu_dp_reg;
    logic       pu_dp_next;
    logic       pu_dm_reg;
    logic       pu_dm_next;

    // fixed pipeline, so the rebuilt edge lags the input edge by a constant, except where the low-speed hold stretches a short state
    always_comb begin
        out_sym_next  = out_sym_reg;
        hold_cnt_next = (hold_cnt_reg != 4'h0) ? hold_cnt_reg - 4'h1 : 4'h0;
        if (st_next == UPIDC_ST_IDLE) begin
            out_sym_next  = UPIDC_SYM_J;
            hold_cnt_next = 4'h0;
        end else if (pop) begin
            out_sym_next  = mem_reg[rd_ptr_reg];
            hold_cnt_next = (fs ? HOLD_FS : HOLD_LS) - 4'h1;
        end
        lvl_next   = drive_levels(out_sym_next, fs);
        // receiver side stays off; driver side on; all off when idle
        up_oe_next = (st_next == UPIDC_ST_PD2UP) && up_ready;
        pd_oe_next = (st_next == UPIDC_ST_UP2PD) && up_ready;
        // peripheral side decides attach time; speed picks which line
        pu_dp_next = pullup_req && pd_pg && fs;
        pu_dm_next = pullup_req && pd_pg && !fs;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            out_sym_reg  <= UPIDC_SYM_J;
            hold_cnt_reg <= 4'h0;
            lvl_reg      <= 2'h0;
            up_oe_reg    <= 1'b0;
            pd_oe_reg    <= 1'b0;
            pu_dp_reg    <= 1'b0;
            pu_dm_reg    <= 1'b0;
        end else begin
            out_sym_reg  <= out_sym_next;
            hold_cnt_reg <= hold_cnt_next;
            lvl_reg      <= lvl_next;
            up_oe_reg    <= up_oe_next;
            pd_oe_reg    <= pd_oe_next;
            pu_dp_reg    <= pu_dp_next;
            pu_dm_reg    <= pu_dm_next;
        end
    end

    // both sides share the rebuilt levels; only one enable is ever high
    assign o_up_dplus               = lvl_reg[1];
    assign o_up_dminus              = lvl_reg[0];
    assign o_up_oe                  = up_oe_reg;
    assign o_peripheral_side_dplus  = lvl_reg[1];
    assign o_peripheral_side_dminus = lvl_reg[0];
    assign o_peripheral_side_oe     = pd_oe_reg;
    assign o_up_pullup_dplus        = pu_dp_reg;
    assign o_up_pullup_dminus       = pu_dm_reg;
    assign o_full_speed             = fs;
    assign o_speed_mismatch         = mismatch;
    assign o_direction              = st_reg;

endmodule : upidc_top

// ### bench/upidc_top_props.sv
// port checks for the isolator direction control, bound into the top
`timescale 1ns/1ps
module upidc_top_props (
    input wire logic              i_clk,
    input wire logic              i_reset_n,
    input wire logic              i_pullup_connect,
    input wire logic              i_up_power_good,
    input wire logic              i_periph_power_good,
    input wire logic              o_up_dplus,
    input wire logic              o_up_dminus,
    input wire logic              o_up_oe,
    input wire logic              o_up_pullup_dplus,
    input wire logic              o_up_pullup_dminus,
    input wire logic              o_peripheral_side_dplus,
    input wire logic              o_peripheral_side_dminus,
    input wire logic              o_peripheral_side_oe,
    input wire logic              o_full_speed,
    input wire logic              o_speed_mismatch,
    input wire upidc_pkg::upidc_state_t o_direction
);
    import upidc_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // a looped drive would latch both sides, so never both at once
    a_one_driver: assert property (!(o_up_oe && o_peripheral_side_oe))
        else $error("both sides drive");
    a_idle_released: assert property ((o_direction == UPIDC_ST_IDLE) [*2] |->
        !o_up_oe && !o_peripheral_side_oe) else $error("driver on while idle");
    a_pd_drive_dir: assert property (o_peripheral_side_oe |->
        o_direction != UPIDC_ST_PD2UP) else $error("peripheral drives while receiving");
    a_up_drive_dir: assert property (o_up_oe |->
        o_direction != UPIDC_ST_UP2PD) else $error("upstream drives while receiving");
    a_no_se1_out: assert property (!(o_up_dplus && o_up_dminus) &&
        !(o_peripheral_side_dplus && o_peripheral_side_dminus)) else $error("se1 rebuilt");
    a_pullup_gate: assert property (!i_pullup_connect [*4] |->
        !o_up_pullup_dplus && !o_up_pullup_dminus) else $error("pull-up without request");
    a_pullup_speed: assert property (!(o_up_pullup_dplus && !o_full_speed) &&
        !(o_up_pullup_dminus && o_full_speed)) else $error("pull-up on wrong line");
    a_periph_loss: assert property (!i_periph_power_good [*6] |-> !o_up_oe &&
        !o_up_pullup_dplus && !o_up_pullup_dminus) else $error("upstream kept after loss");
    a_up_loss: assert property (!i_up_power_good [*6] |->
        !o_peripheral_side_oe) else $error("peripheral kept driving after loss");
    a_mismatch_hold: assert property (o_speed_mismatch &&
        o_direction == UPIDC_ST_IDLE |=> o_direction == UPIDC_ST_IDLE)
        else $error("transfer under mixed speed");

    c_up2pd: cover property (o_direction == UPIDC_ST_UP2PD && o_peripheral_side_oe);
    c_pd2up: cover property (o_direction == UPIDC_ST_PD2UP && o_up_oe);
    c_loss: cover property (!i_up_power_good [*6]);
endmodule : upidc_top_props

bind upidc_top upidc_top_props i_props (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_pullup_connect(i_pullup_connect),
    .i_up_power_good(i_up_power_good), .i_periph_power_good(i_periph_power_good),
    .o_up_dplus(o_up_dplus), .o_up_dminus(o_up_dminus), .o_up_oe(o_up_oe),
    .o_up_pullup_dplus(o_up_pullup_dplus), .o_up_pullup_dminus(o_up_pullup_dminus),
    .o_peripheral_side_dplus(o_peripheral_side_dplus),
    .o_peripheral_side_dminus(o_peripheral_side_dminus),
    .o_peripheral_side_oe(o_peripheral_side_oe), .o_full_speed(o_full_speed),
    .o_speed_mismatch(o_speed_mismatch), .o_direction(o_direction)
);

// ### bench/upidc_far_model.sv
// line drivers of the usb host cable and the peripheral controller
`timescale 1ns/1ps
module upidc_far_model (
    input  wire logic i_full_speed,
    output logic      o_up_dp,
    output logic      o_up_dm,
    output logic      o_up_df,
    output logic      o_pd_dp,
    output logic      o_pd_dm,
    output logic      o_pd_df
);
    import upidc_pkg::*;
    logic [2:0] up_reg = 3'h5;
    logic [2:0] pd_reg = 3'h5;

    // d+, d-, diff; j flips with speed, se1 never produced
    function automatic logic [2:0] levels(input upidc_sym_t s, input logic fs);
        case (s)
            UPIDC_SYM_J: return fs ? 3'h5 : 3'h2;
            UPIDC_SYM_K: return fs ? 3'h2 : 3'h5;
            default:     return 3'h0;
        endcase
    endfunction : levels

    // both parties rest at j between packets, no suspend signalling
    task automatic drive(input bit side_pd, input upidc_sym_t s);
        if (side_pd) pd_reg = levels(s, i_full_speed);
        else up_reg = levels(s, i_full_speed);
    endtask : drive

    // raw pin levels, for line conditions a clean driver never makes
    task automatic drive_raw(input bit side_pd, input logic [2:0] lv);
        if (side_pd) pd_reg = lv;
        else up_reg = lv;
    endtask : drive_raw

    assign {o_up_dp, o_up_dm, o_up_df} = up_reg;
    assign {o_pd_dp, o_pd_dm, o_pd_df} = pd_reg;
endmodule : upidc_far_model

// ### bench/testbench.sv
// self-checking bench for the isolator direction control
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
    $display("Error %s expected %0h seen %0h", nm, ex, gt); n_errors++; end end
module testbench;
    import upidc_pkg::*;
    logic         i_clk, i_reset_n, sp_up, sp_dn, pu_en, up_pg, pd_pg;
    wire logic    a_dp, a_dm, a_df, b_dp, b_dm, b_df;
    logic         up_dp, up_dm, up_oe, pu_dp, pu_dm, pd_dp, pd_dm, pd_oe, fs, mis;
    upidc_state_t dir;
    int           n_errors = 0;
    int           n_checks = 0;

    // 25 mhz system clock
    always #20 i_clk = ~i_clk;

    upidc_top i_dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_upstream_speed_select(sp_up),
        .i_downstream_speed_select(sp_dn), .i_pullup_connect(pu_en),
        .i_up_power_good(up_pg), .i_periph_power_good(pd_pg),
        .i_up_dplus(a_dp), .i_up_dminus(a_dm), .i_up_diff(a_df),
        .i_peripheral_side_dplus(b_dp), .i_peripheral_side_dminus(b_dm),
        .i_peripheral_side_diff(b_df), .o_up_dplus(up_dp), .o_up_dminus(up_dm),
        .o_up_oe(up_oe), .o_up_pullup_dplus(pu_dp), .o_up_pullup_dminus(pu_dm),
        .o_peripheral_side_dplus(pd_dp), .o_peripheral_side_dminus(pd_dm),
        .o_peripheral_side_oe(pd_oe), .o_full_speed(fs), .o_speed_mismatch(mis),
        .o_direction(dir)
    );
    upidc_far_model i_far (
        .i_full_speed(sp_up), .o_up_dp(a_dp), .o_up_dm(a_dm), .o_up_df(a_df),
        .o_pd_dp(b_dp), .o_pd_dm(b_dm), .o_pd_df(b_df)
    );

    // inputs always move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    task automatic give_verdict;
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // bounded wait; running out ends the run
    task automatic wait_dir(input upidc_state_t ex, input int bound);
        for (int k = 0; k < bound && dir !== ex; k++) tick(1);
        `CHK("direction", ex, dir)
        if (dir !== ex) give_verdict();
    endtask : wait_dir

    task automatic chk_lv(input bit side_up, input upidc_sym_t s);
        logic [2:0] e;
        e = i_far.levels(s, sp_up);
        if (side_up) `CHK("up lines", e[2:1], {up_dp, up_dm})
        else `CHK("pd lines", e[2:1], {pd_dp, pd_dm})
    endtask : chk_lv

    task automatic do_reset;
        i_reset_n = 0;
        tick(6);
        i_reset_n = 1;
        tick(1);
    endtask : do_reset

    task automatic t_start;
        do_reset();
        `CHK("pd oe", 1'b0, pd_oe)
        `CHK("up oe", 1'b0, up_oe)
        tick(4);
        `CHK("pullup", 2'h0, {pu_dp, pu_dm})
        pu_en = 1;
        tick(5);
        `CHK("pullup", 2'h2, {pu_dp, pu_dm})
        `CHK("full speed", 1'b1, fs)
    endtask : t_start

    // host packet with a looped-back attempt and a one-sample glitch
    task automatic t_up2pd;
        i_far.drive(0, UPIDC_SYM_K);
        tick(3);
        `CHK("pd oe", 1'b0, pd_oe)
        tick(3);
        `CHK("direction", UPIDC_ST_UP2PD, dir)
        `CHK("up oe", 1'b0, up_oe)
        `CHK("pd oe", 1'b1, pd_oe)
        chk_lv(0, UPIDC_SYM_K);
        i_far.drive(1, UPIDC_SYM_SE0);
        i_far.drive(0, UPIDC_SYM_J);
        tick(6);
        chk_lv(0, UPIDC_SYM_J);
        `CHK("direction", UPIDC_ST_UP2PD, dir)
        i_far.drive(1, UPIDC_SYM_J);
        i_far.drive(0, UPIDC_SYM_SE0);
        tick(1);
        i_far.drive(0, UPIDC_SYM_J);
        repeat (6) begin
            tick(1);
            chk_lv(0, UPIDC_SYM_J);
        end
        // se1 with diff low: the diff receiver decides, so k and never se1
        i_far.drive_raw(0, 3'h6);
        tick(6);
        chk_lv(0, UPIDC_SYM_K);
        i_far.drive(0, UPIDC_SYM_SE0);
        tick(4);
        i_far.drive(0, UPIDC_SYM_J);
        tick(2);
        chk_lv(0, UPIDC_SYM_SE0);
        wait_dir(UPIDC_ST_IDLE, 16);
        `CHK("pd oe", 1'b0, pd_oe)
    endtask : t_up2pd

    // peripheral answer that stalls and ends by idle timeout
    task automatic t_pd2up;
        i_far.drive(1, UPIDC_SYM_K);
        tick(6);
        `CHK("direction", UPIDC_ST_PD2UP, dir)
        `CHK("up oe", 1'b1, up_oe)
        chk_lv(1, UPIDC_SYM_K);
        // sixteen quiet cycles since the K, past seven full-speed bit times
        tick(10);
        `CHK("direction", UPIDC_ST_PD2UP, dir)
        wait_dir(UPIDC_ST_IDLE, 24);
        `CHK("up oe", 1'b0, up_oe)
        i_far.drive(1, UPIDC_SYM_J);
        tick(6);
        `CHK("direction", UPIDC_ST_IDLE, dir)
    endtask : t_pd2up

    task automatic t_mismatch;
        sp_dn = 0;
        tick(4);
        `CHK("mismatch", 1'b1, mis)
        i_far.drive(0, UPIDC_SYM_K);
        tick(8);
        `CHK("direction", UPIDC_ST_IDLE, dir)
        i_far.drive(0, UPIDC_SYM_J);
        sp_dn = 1;
        tick(4);
        `CHK("mismatch", 1'b0, mis)
    endtask : t_mismatch

    // low speed: swapped polarity and the long hold of a short K state
    task automatic t_low;
        sp_up = 0;
        sp_dn = 0;
        i_far.drive(0, UPIDC_SYM_J);
        i_far.drive(1, UPIDC_SYM_J);
        do_reset();
        tick(4);
        `CHK("pullup", 2'h1, {pu_dp, pu_dm})
        i_far.drive(0, UPIDC_SYM_K);
        tick(2);
        i_far.drive(0, UPIDC_SYM_J);
        tick(4);
        chk_lv(0, UPIDC_SYM_K);
        tick(6);
        chk_lv(0, UPIDC_SYM_K);
        tick(4);
        chk_lv(0, UPIDC_SYM_J);
    endtask : t_low

    task automatic t_power;
        `CHK("pd oe", 1'b1, pd_oe)
        up_pg = 0;
        tick(6);
        `CHK("pd oe", 1'b0, pd_oe)
        up_pg = 1;
        pd_pg = 0;
        tick(6);
        `CHK("pullup", 2'h0, {pu_dp, pu_dm})
        `CHK("up oe", 1'b0, up_oe)
        pd_pg = 1;
        tick(6);
        `CHK("pullup", 2'h1, {pu_dp, pu_dm})
    endtask : t_power

    initial begin
        i_clk = 0;
        i_reset_n = 0;
        sp_up = 1;
        sp_dn = 1;
        pu_en = 0;
        up_pg = 1;
        pd_pg = 1;
        t_start();
        t_up2pd();
        t_pd2up();
        t_mismatch();
        t_low();
        t_power();
        give_verdict();
    end
endmodule : testbench
